/* File: rtl/xsd_decode.sv */
// decode and execute slice: xor forms, test-and-skip, extension gating
// assumes: instr_valid_i presents one fetched word per four-phase cycle,
// next_word_i shows the word after the current one, data read is
// combinational from the register file
`timescale 1ns/10ps

module xsd_decode
	import xsd_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic instr_valid_i,
	input wire logic [15:0] instr_i,
	input wire logic [15:0] next_word_i,
	input wire logic extension_enable_bit_i,
	input wire logic [3:0] bank_select_reg_i,
	input wire logic [11:0] pointer_two_i,
	input wire logic [7:0] file_rd_data_i,
	output logic [11:0] file_rd_addr_o,
	output logic indexed_o,
	output xsd_mem_wr_t file_wr_o,
	output logic [7:0] accum_o,
	output xsd_flags_t flags_o,
	output xsd_ptr_op_t ptr_op_o,
	output xsd_phase_t phase_o,
	output logic skip_active_o,
	output logic fetch_discard_o,
	output logic busy_o
);

	// ****************************************************
	// decode
	// ****************************************************
	xsd_phase_t phase_reg;
	logic [7:0] accum_reg;
	xsd_flags_t flags_reg;
	xsd_mem_wr_t wr_reg;
	xsd_ptr_op_t ptr_reg;
	logic [1:0] skip_cnt_reg;
	logic [15:0] op_reg;
	logic op_live_reg;
	logic [7:0] result_reg;
	logic [1:0] next_words;
	logic is_xor_lit;
	logic is_xor_file;
	logic is_test_skip;
	logic is_ptr_two_ret;
	logic in_skip;
	logic take_op;

	assign in_skip = (skip_cnt_reg != 2'h0);
	assign take_op = instr_valid_i && (phase_reg == XSD_DECODE) && !in_skip;

	assign is_xor_lit = (op_reg[15:8] == OP_XOR_LIT_HI);
	assign is_xor_file = (op_reg[15:10] == OP_XOR_FILE_HI);
	assign is_test_skip = (op_reg[15:9] == OP_TEST_SKIP_HI);
	assign is_ptr_two_ret = extension_enable_bit_i
		&& (op_reg[15:8] == OP_ADD_PTR_HI || op_reg[15:8] == OP_SUB_PTR_HI)
		&& (op_reg[7:6] == PTR_TWO_SEL);

	xsd_addr_gen u_addr_gen (
		.file_i(op_reg[7:0]),
		.bank_bit_i(op_reg[BANK_BIT]),
		.ext_en_i(extension_enable_bit_i),
		.bank_select_reg_i(bank_select_reg_i),
		.pointer_two_i(pointer_two_i),
		.addr_o(file_rd_addr_o),
		.indexed_o(indexed_o)
	);

	xsd_word_len u_word_len (
		.word_i(next_word_i),
		.ext_en_i(extension_enable_bit_i),
		.words_o(next_words)
	);

	// ****************************************************
	// phase sequencer
	// ****************************************************
	// four phase cycle
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			phase_reg <= XSD_DECODE;
		end else begin
			case (phase_reg)
				XSD_DECODE: begin
					if (instr_valid_i || in_skip) begin
						phase_reg <= XSD_READ;
					end
				end
				XSD_READ: phase_reg <= XSD_PROCESS;
				XSD_PROCESS: phase_reg <= XSD_WRITE;
				XSD_WRITE: phase_reg <= XSD_DECODE;
				default: phase_reg <= XSD_DECODE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			op_reg <= 16'h0000;
			op_live_reg <= 1'b0;
		end else if (take_op) begin
			op_reg <= instr_i;
			op_live_reg <= 1'b1;
		end else if (phase_reg == XSD_WRITE) begin
			op_live_reg <= 1'b0;
		end
	end

	// ****************************************************
	// data path
	// ****************************************************
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			result_reg <= 8'h00;
		end else if (phase_reg == XSD_READ && op_live_reg) begin
			if (is_xor_lit) begin
				result_reg <= accum_reg ^ op_reg[7:0];
			end else begin
				result_reg <= accum_reg ^ file_rd_data_i;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			accum_reg <= ACCUM_RESET;
			flags_reg <= '0;
			wr_reg <= '0;
		end else begin
			wr_reg.en <= 1'b0;
			if (phase_reg == XSD_PROCESS && op_live_reg
					&& (is_xor_lit || is_xor_file)) begin
				flags_reg.n <= result_reg[SIGN_BIT];
				flags_reg.z <= (result_reg == 8'h00);
				if (is_xor_file && op_reg[DEST_BIT]) begin
					wr_reg.en <= 1'b1;
					wr_reg.addr <= file_rd_addr_o;
					wr_reg.data <= result_reg;
				end else begin
					accum_reg <= result_reg;
				end
			end
		end
	end

	// ****************************************************
	// skip control
	// ****************************************************
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			skip_cnt_reg <= 2'h0;
		end else if (phase_reg == XSD_WRITE) begin
			if (in_skip) begin
				skip_cnt_reg <= skip_cnt_reg - 2'h1;
			end else if (op_live_reg && is_test_skip
					&& file_rd_data_i == 8'h00) begin
				skip_cnt_reg <= next_words;
			end
		end
	end

	// ****************************************************
	// pointer two extended ops
	// ****************************************************
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ptr_reg <= '0;
		end else begin
			ptr_reg.en <= 1'b0;
			if (phase_reg == XSD_PROCESS && op_live_reg && is_ptr_two_ret) begin
				ptr_reg.en <= 1'b1;
				ptr_reg.sel <= PTR_TWO_SEL;
				ptr_reg.sub <= (op_reg[15:8] == OP_SUB_PTR_HI);
				ptr_reg.amount <= op_reg[5:0];
				ptr_reg.ret <= 1'b1;
			end
		end
	end

	// ****************************************************
	// outputs
	// ****************************************************
	assign accum_o = accum_reg;
	assign flags_o = flags_reg;
	assign file_wr_o = wr_reg;
	assign ptr_op_o = ptr_reg;
	assign phase_o = phase_reg;
	assign skip_active_o = in_skip;
	assign fetch_discard_o = in_skip && (phase_reg == XSD_DECODE);
	assign busy_o = op_live_reg || in_skip;

endmodule : xsd_decode

/* File: rtl/xsd_pkg.sv */
// package for the xor / skip / extension decode slice
// assumes: 16-bit instruction words, 8-bit data path, 12-bit data addresses
package xsd_pkg;

	// ****************************************************
	// opcode fields
	// ****************************************************
	localparam logic [7:0] OP_XOR_LIT_HI = 8'h0A;
	localparam logic [5:0] OP_XOR_FILE_HI = 6'h06;
	localparam logic [6:0] OP_TEST_SKIP_HI = 7'h33;
	localparam logic [7:0] OP_ADD_PTR_HI = 8'hE8;
	localparam logic [7:0] OP_SUB_PTR_HI = 8'hE9;
	localparam logic [1:0] PTR_TWO_SEL = 2'h3;
	localparam logic [7:0] OP_PUSH_LIT_HI = 8'hEA;
	localparam logic [6:0] OP_MOVE_EXT_HI = 7'h75;
	localparam logic [3:0] OP_SECOND_HI = 4'hF;
	localparam logic [7:0] OP_MOVE_LONG_HI = 8'h00;
	localparam logic [7:0] OP_MOVE_LONG_LO = 8'h02;
	localparam logic [7:0] OP_CALL_HI = 8'hEC;
	localparam logic [7:0] OP_GOTO_HI = 8'hEF;
	localparam logic [6:0] OP_LFSR_HI = 7'h77;
	localparam int DEST_BIT = 9;
	localparam int BANK_BIT = 8;
	localparam int SIGN_BIT = 7;
	localparam logic [7:0] INDEX_LIMIT = 8'h5F;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;

	// ****************************************************
	// reset values and phases
	// ****************************************************
	localparam logic [7:0] ACCUM_RESET = 8'h00;
	localparam logic [1:0] PHASE_LAST = 2'h3;
	localparam logic [1:0] SKIP_MAX = 2'h3;

	typedef enum logic [1:0] {
		XSD_DECODE = 2'b00,
		XSD_READ = 2'b01,
		XSD_PROCESS = 2'b11,
		XSD_WRITE = 2'b10
	} xsd_phase_t;

	typedef struct packed {
		logic n;
		logic z;
	} xsd_flags_t;

	typedef struct packed {
		logic en;
		logic [11:0] addr;
		logic [7:0] data;
	} xsd_mem_wr_t;

	typedef struct packed {
		logic en;
		logic [1:0] sel;
		logic sub;
		logic [5:0] amount;
		logic ret;
	} xsd_ptr_op_t;

endpackage : xsd_pkg

/* File: rtl/xsd_addr_gen.sv */
// data address generator for byte-oriented file operations
// assumes: pointer two value and bank select supplied by the core
`timescale 1ns/10ps
module xsd_addr_gen
	import xsd_pkg::*;
(
	input wire logic [7:0] file_i,
	input wire logic bank_bit_i,
	input wire logic ext_en_i,
	input wire logic [3:0] bank_select_reg_i,
	input wire logic [11:0] pointer_two_i,
	output logic [11:0] addr_o,
	output logic indexed_o
);
	always_comb begin
		indexed_o = 1'b0;
		if (bank_bit_i) begin
			addr_o = {bank_select_reg_i, file_i};
		end else if (ext_en_i && (file_i <= INDEX_LIMIT)) begin
			indexed_o = 1'b1;
			addr_o = 12'(pointer_two_i + {4'h0, file_i});
		end else if (file_i < ACCESS_SPLIT) begin
			addr_o = {4'h0, file_i};
		end else begin
			addr_o = {ACCESS_HI_BANK, file_i};
		end
	end
endmodule : xsd_addr_gen

/* File: rtl/xsd_word_len.sv */
// instruction length classifier used to size the skip
// assumes: word presented is the one following the test instruction
`timescale 1ns/10ps
module xsd_word_len
	import xsd_pkg::*;
(
	input wire logic [15:0] word_i,
	input wire logic ext_en_i,
	output logic [1:0] words_o
);
	always_comb begin
		words_o = 2'h1;
		// call matches both states of its fast-return bit
		if (word_i[15:9] == OP_CALL_HI[7:1] || word_i[15:8] == OP_GOTO_HI
				|| word_i[15:9] == OP_LFSR_HI
				|| word_i[15:12] == 4'hC) begin
			words_o = 2'h2;
		// push literal is the one-word member of this group
		end else if (ext_en_i && word_i[15:9] == OP_MOVE_EXT_HI
				&& word_i[15:8] != OP_PUSH_LIT_HI) begin
			words_o = 2'h2;
		end else if (ext_en_i && word_i[15:8] == OP_MOVE_LONG_HI
				&& word_i[7:0] == OP_MOVE_LONG_LO) begin
			words_o = SKIP_MAX;
		end
	end
endmodule : xsd_word_len

/* File: tb/xsd_file_mem.sv */
// data register file model on the far side of the decode slice
// assumes: reads answer at once, writes land on the clock edge
`timescale 1ns/10ps
module xsd_file_mem
	import xsd_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic [11:0] file_rd_addr_i,
	input wire xsd_mem_wr_t file_wr_i,
	output logic [7:0] file_rd_data_o
);
	// ****************************************
	// storage
	// ****************************************
	logic [7:0] mem [0:4095];
	assign file_rd_data_o = mem[file_rd_addr_i];
	always @(posedge ref_clk_i) begin
		if (file_wr_i.en) begin
			mem[file_wr_i.addr] <= file_wr_i.data;
		end
	end
endmodule : xsd_file_mem

/* File: tb/xsd_decode_asserts.sv */
// port checker for the decode slice
// assumes: bound to xsd_decode, one clock domain
`timescale 1ns/10ps
module xsd_decode_asserts
	import xsd_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic extension_enable_bit_i,
	input wire logic indexed_o,
	input wire xsd_mem_wr_t file_wr_o,
	input wire logic [7:0] accum_o,
	input wire xsd_flags_t flags_o,
	input wire xsd_ptr_op_t ptr_op_o,
	input wire xsd_phase_t phase_o,
	input wire logic skip_active_o,
	input wire logic fetch_discard_o
);
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);
	AST_PHASE_RUN: assert property (
		phase_o == XSD_READ |=> phase_o == XSD_PROCESS ##1
		phase_o == XSD_WRITE ##1 phase_o == XSD_DECODE)
		else $error("phase order broken");
	AST_FLAGS: assert property ($changed(accum_o) |->
		flags_o.n == accum_o[SIGN_BIT] && flags_o.z == (accum_o == 8'h00))
		else $error("flags disagree with accumulator");
	AST_WR_PULSE: assert property (
		file_wr_o.en |=> !file_wr_o.en)
		else $error("file write longer than one cycle");
	AST_INDEX_GATE: assert property (
		indexed_o |-> extension_enable_bit_i)
		else $error("indexed address while extension off");
	AST_SKIP_LEN: assert property ($rose(skip_active_o) |->
		skip_active_o[*4] ##[1:9] !skip_active_o)
		else $error("skip length out of range");
	AST_SKIP_ALIGN: assert property ($fell(skip_active_o) |->
		phase_o == XSD_DECODE)
		else $error("skip ended mid cycle");
	AST_SKIP_QUIET: assert property (skip_active_o |=>
		$stable(accum_o) && !file_wr_o.en && !ptr_op_o.en)
		else $error("state changed while skipping");
	AST_DISCARD: assert property (fetch_discard_o |->
		skip_active_o && phase_o == XSD_DECODE)
		else $error("discard outside idle cycle");
	AST_PTR_TWO: assert property (ptr_op_o.en && ptr_op_o.ret |->
		ptr_op_o.sel == PTR_TWO_SEL && extension_enable_bit_i)
		else $error("return form not on pointer two");
	cover property ($rose(skip_active_o));
	cover property (file_wr_o.en);
	cover property (ptr_op_o.en && ptr_op_o.ret);
endmodule : xsd_decode_asserts
bind xsd_decode xsd_decode_asserts u_xsd_chk (.*);

/* File: tb/xsd_decode_tb.sv */
// self-checking bench for the xor / skip / extension decode slice
// assumes: words come from the bench, data from xsd_file_mem
`timescale 1ns/10ps
module xsd_decode_tb import xsd_pkg::*;;
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic instr_valid_i = 1'b0;
	logic [15:0] instr_i = 16'h0000;
	logic [15:0] next_word_i = 16'h0000;
	logic extension_enable_bit_i = 1'b0;
	logic [3:0] bank_select_reg_i = 4'h0;
	logic [11:0] pointer_two_i = 12'h000;
	logic [7:0] file_rd_data_i, accum_o, e;
	logic [11:0] file_rd_addr_o;
	logic indexed_o, skip_active_o, fetch_discard_o, busy_o;
	xsd_mem_wr_t file_wr_o;
	xsd_flags_t flags_o;
	xsd_ptr_op_t ptr_op_o, ptr_seen;
	xsd_phase_t phase_o;
	int miscompares = 0;
	int samples_checked = 0;
	int n;
	int dc;
	int ptr_cnt = 0;
	logic [11:0] ia [4] = '{12'h110, 12'h15F, 12'hF60, 12'h010};
	logic [7:0] fa [4] = '{8'h10, 8'h5F, 8'h60, 8'h10};
	logic [15:0] sw [4] = '{16'h0A00, 16'hEF00, 16'h0002, 16'h0A00};
	int sn [4] = '{1, 2, 3, 0};
	// ****************************************
	// harness
	// ****************************************
	always #20 ref_clk_i = ~ref_clk_i;
	xsd_decode DUT (.*);
	xsd_file_mem PM (.ref_clk_i, .file_rd_addr_i(file_rd_addr_o),
		.file_wr_i(file_wr_o), .file_rd_data_o(file_rd_data_i));
	always @(posedge ref_clk_i) begin
		if (ptr_op_o.en) begin
			ptr_seen <= ptr_op_o;
			ptr_cnt <= ptr_cnt + 1;
		end
	end
	task automatic check(input logic [15:0] s, input logic [15:0] x);
		samples_checked++;
		if (s !== x) begin
			miscompares++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask : check
	task automatic exec(input logic [15:0] w, input logic [15:0] nw);
		while (phase_o !== XSD_DECODE || skip_active_o !== 1'b0) begin
			@(negedge ref_clk_i);
		end
		instr_i = w;
		next_word_i = nw;
		instr_valid_i = 1'b1;
		@(negedge ref_clk_i);
		instr_valid_i = 1'b0;
		repeat (3) @(negedge ref_clk_i);
	endtask : exec
	task automatic stop_test;
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test
	initial begin
		repeat (1000) @(posedge ref_clk_i);
		miscompares++;
		stop_test();
	end
	initial begin
		repeat (10) @(negedge ref_clk_i);
		reset_i = 1'b0;
		exec(16'h0AB5, 16'h0000);
		check(accum_o, 8'hB5);
		check(flags_o, 2'b10);
		exec(16'h0AAF, 16'h0000);
		check(accum_o, 8'h1A);
		check(busy_o, 1'b0);
		exec(16'h0A1A, 16'h0000);
		check(flags_o, 2'b01);
		PM.mem[12'h020] = 8'hAF;
		PM.mem[12'h530] = 8'h0F;
		PM.mem[12'hF80] = 8'h1A;
		bank_select_reg_i = 4'h5;
		exec(16'h0AB5, 16'h0000);
		exec(16'h1A20, 16'h0000);
		check(accum_o, 8'hB5);
		check(flags_o, 2'b00);
		exec(16'h1930, 16'h0000);
		check(accum_o, 8'hBA);
		check(PM.mem[12'h020], 8'h1A);
		exec(16'h1880, 16'h0000);
		check(accum_o, 8'hA0);
		check(file_rd_addr_o, 12'hF80);
		e = 8'hA0;
		pointer_two_i = 12'h100;
		for (int i = 0; i < 4; i++) begin
			extension_enable_bit_i = (i < 3);
			PM.mem[ia[i]] = {6'h0C, i[1:0]};
			e = e ^ {6'h0C, i[1:0]};
			exec({8'h18, fa[i]}, 16'h0000);
			check(accum_o, e);
			check(file_rd_addr_o, ia[i]);
			check(indexed_o, i < 2);
		end
		for (int i = 0; i < 4; i++) begin
			extension_enable_bit_i = (i == 2);
			PM.mem[12'h520] = (i == 3) ? 8'h05 : 8'h00;
			exec(16'h6720, sw[i]);
			instr_i = 16'h0AFF;
			n = 0;
			dc = 0;
			while (skip_active_o && n < 20) begin
				instr_valid_i = 1'b1;
				if (fetch_discard_o) begin
					dc++;
				end
				@(negedge ref_clk_i);
				n++;
			end
			instr_valid_i = 1'b0;
			check(n[15:0], 16'(4 * sn[i]));
			check(dc[15:0], sn[i][15:0]);
			check(accum_o, e);
			check(busy_o, 1'b0);
		end
		extension_enable_bit_i = 1'b0;
		exec(16'hE8C5, 16'h0000);
		@(negedge ref_clk_i);
		check(16'(ptr_cnt), 16'h0000);
		extension_enable_bit_i = 1'b1;
		exec(16'hE8C5, 16'h0000);
		@(negedge ref_clk_i);
		check(ptr_seen, 11'h70B);
		check(16'(ptr_cnt), 16'h0001);
		exec(16'hE9C5, 16'h0000);
		@(negedge ref_clk_i);
		check(ptr_seen, 11'h78B);
		exec(16'hE845, 16'h0000);
		@(negedge ref_clk_i);
		check(16'(ptr_cnt), 16'h0002);
		stop_test();
	end
endmodule : xsd_decode_tb
